/* design/ptq_pkg.sv */
// Package of constants and types for the pulse tally block
package ptq_pkg;
    // Operating mode field encodings
    typedef enum logic [1:0] {
        PTQ_MODE_DISABLED = 2'h0,
        PTQ_MODE_SAMPLED  = 2'h1,
        PTQ_MODE_PINCLK   = 2'h2,
        PTQ_MODE_QUAD     = 2'h3
    } ptq_mode_e;
    // Event select encodings (main and secondary)
    localparam logic [1:0] PTQ_EV_BOTH = 2'h0;  // Count up and down events
    localparam logic [1:0] PTQ_EV_UP   = 2'h1;  // Only up events
    localparam logic [1:0] PTQ_EV_DOWN = 2'h2;  // Only down events
    localparam logic [1:0] PTQ_EV_NONE = 2'h3;  // No events
    // Glitch filter stable period in sampling clock cycles
    localparam int PTQ_GLITCH_REJECT_ENABLE_CYCLES = 5;
    // Default widths
    localparam int PTQ_CNT_W = 16;
endpackage : ptq_pkg

/* design/ptq_filter.sv */
// Pulse width filter: passes a level after it held for STABLE samples
module ptq_filter #(
    parameter int STABLE = 5
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic SAMPLE,
    input  wire logic ENABLE,
    input  wire logic DIN,
    output logic      DOUT
);
    localparam int CW = $clog2(STABLE + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE - 1);
    logic [CW-1:0] run;   // Samples of the new level seen so far
    logic          level; // Filtered level

    // Count consecutive samples differing from the filtered level
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            run   <= '0;
            level <= 1'b0;
        end else if (!ENABLE) begin
            // Filter bypassed: follow the input directly
            run   <= '0;
            level <= DIN;
        end else if (SAMPLE) begin
            if (DIN == level) begin
                run <= '0;
            end else if (run == LAST) begin
                // Held for the full stable period
                run   <= '0;
                level <= DIN;
            end else begin
                run <= run + CW'(1);
            end
        end
    end

    // Output changes only to the level the input had the cycle before
    a_filter_hold : assert property (@(posedge CLK) disable iff (!RESET_N)
        ENABLE && $past(ENABLE) && $changed(level) |-> level == $past(DIN))
        else $error("filter output moved to a level not on the input");

    assign DOUT = level;
endmodule // ptq_filter

/* design/ptq_tally.sv */
// Pulse and quadrature counter with main and secondary counters
// Notes on behaviour
// - Mode selects sampled counting; disabled stops counting
// - Filter enable inserts glitch filter before edge detect
// - Invert flips input a; falling edges counted
// - Sampled mode observes input a, counts edges
// - Count up by default, down when selected
// - Input b high keeps direction, low reverses
// - Pin-clocked single counts rising a edges
// - No filtering in pin-clocked modes
// - Quadrature samples b on both a edges
// - A leading b one sense; invert flips it
// - Report direction, flag counted steps whose direction differs from status
// - Quadrature table: 01 count dir0, 10 dir1
// - Wrap up past limit to zero, down to limit
// - Midpoint wrap loads half limit on wraps
// - Secondary counter only increments on selected events
// - Secondary passing limit flags and wraps zero
// - Main counter counts only selected event kinds
// - Input a clocks counting in pin-clocked modes
// - Flags on underflow, overflow, quadrature reversal
// - Underflow at zero down, then load limit
// - Overflow at limit up, then load zero
// - Filter needs five stable cycles each level
// - Invert ignored in pin-clocked single mode
module ptq_tally
    import ptq_pkg::*;
#(
    parameter int CNT_W = ptq_pkg::PTQ_CNT_W
) (
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic             COUNT_INPUT_A,
    input  wire logic             COUNT_INPUT_B,
    input  wire logic             LOW_FREQ_CLOCK,
    input  wire ptq_pkg::ptq_mode_e MODE,
    input  wire logic             GLITCH_REJECT_ENABLE,
    input  wire logic             INPUT_INVERT,
    input  wire logic             PIN_STEERED_DIRECTION,
    input  wire logic             COUNT_DOWN_SELECT,
    input  wire logic             MIDPOINT_WRAP_ENABLE,
    input  wire logic [1:0]       MAIN_COUNT_EVENT_SELECT,
    input  wire logic [1:0]       SECONDARY_COUNT_EVENT_SELECT,
    input  wire logic [CNT_W-1:0] WRAP_LIMIT,
    input  wire logic             FLAG_CLEAR,
    output logic [CNT_W-1:0]      MAIN_COUNT_VALUE,
    output logic [CNT_W-1:0]      SECONDARY_COUNT_VALUE,
    output logic                  COUNT_SENSE_STATUS,
    output logic                  UNDERFLOW_FLAG,
    output logic                  OVERFLOW_FLAG,
    output logic                  REVERSAL_FLAG,
    output logic                  SECONDARY_WRAP_FLAG
);
    import ptq_pkg::*;

    // Synchroniser stages for pins and the sampling clock
    logic [1:0] sync_a;    // Input a: first stage bit 0
    logic [1:0] sync_b;    // Input b
    logic [1:0] sync_lf;   // Low frequency sampling clock
    logic       lf_prev;   // Previous synced sampling clock
    logic       a_prev;    // Previous raw-synced input a
    logic       f_prev;    // Previous filtered input a
    logic       b_at_rise; // Input b captured at a rise
    logic       b_at_fall; // Input b captured at a fall
    logic       glitch_reject_enable_a;    // Filtered sampled input a
    logic       lf_tick;   // One cycle per sampling clock rise

    // Event decode
    logic       event_hit;  // A count event this cycle
    logic       event_down; // Its direction is downward
    logic       quad_dir;   // Quadrature direction now

    // Two flip-flops on inputs a, b and the sampling clock before use
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync_a  <= 2'h0;
            sync_b  <= 2'h0;
            sync_lf <= 2'h0;
        end else begin
            sync_a  <= {sync_a[0], COUNT_INPUT_A};
            sync_b  <= {sync_b[0], COUNT_INPUT_B};
            sync_lf <= {sync_lf[0], LOW_FREQ_CLOCK};
        end
    end

    // Edge history of synced signals
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lf_prev <= 1'b0;
            a_prev  <= 1'b0;
            f_prev  <= 1'b0;
        end else begin
            lf_prev <= sync_lf[1];
            a_prev  <= sync_a[1];
            if (lf_tick) begin
                f_prev <= glitch_reject_enable_a;
            end
        end
    end

    assign lf_tick = sync_lf[1] && !lf_prev;

    // Glitch filter on sampled input a, only in sampled mode
    ptq_filter #(
        .STABLE (PTQ_GLITCH_REJECT_ENABLE_CYCLES)
    ) u_filter (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .SAMPLE  (lf_tick),
        .ENABLE  (GLITCH_REJECT_ENABLE && MODE == PTQ_MODE_SAMPLED),
        .DIN     (sync_a[1] ^ INPUT_INVERT),
        .DOUT    (glitch_reject_enable_a)
    );

    // Edges seen in the link domain and in the sampled domain
    logic a_rise;   // Rising edge of synced input a
    logic a_fall;   // Falling edge of synced input a
    logic s_edge;   // Active edge of sampled filtered input a
    assign a_rise = sync_a[1] && !a_prev;
    assign a_fall = !sync_a[1] && a_prev;
    assign s_edge = lf_tick && glitch_reject_enable_a && !f_prev;

    // Capture input b on each edge of input a for quadrature
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            b_at_rise <= 1'b0;
            b_at_fall <= 1'b0;
        end else if (MODE == PTQ_MODE_QUAD) begin
            if (a_rise) begin
                b_at_rise <= sync_b[1];
            end
            if (a_fall) begin
                b_at_fall <= sync_b[1];
            end
        end
    end

    // Quadrature table, evaluated on each a edge with the fresh sample
    logic q_pos;   // b sampled at rise (fresh on rise)
    logic q_neg;   // b sampled at fall (fresh on fall)
    logic q_en;    // Table count enable
    logic q_raw;   // Table direction bit
    always_comb begin
        q_pos = a_rise ? sync_b[1] : b_at_rise;
        q_neg = a_fall ? sync_b[1] : b_at_fall;
        q_en  = q_pos ^ q_neg;
        q_raw = q_pos && !q_neg;
    end
    // Invert setting flips the sense of a leading b
    assign quad_dir = q_raw ^ INPUT_INVERT;

    // Direction and event decode per mode
    always_comb begin
        event_hit  = 1'b0;
        event_down = COUNT_DOWN_SELECT;
        case (MODE)
            PTQ_MODE_SAMPLED: begin
                // Count active sampled edges of input a
                event_hit = s_edge;
                if (PIN_STEERED_DIRECTION) begin
                    event_down = sync_b[1] ? COUNT_DOWN_SELECT
                                           : !COUNT_DOWN_SELECT;
                end
            end
            PTQ_MODE_PINCLK: begin
                // Raw rising edges, no filter, no invert
                event_hit = a_rise;
                if (PIN_STEERED_DIRECTION) begin
                    event_down = sync_b[1] ? COUNT_DOWN_SELECT
                                           : !COUNT_DOWN_SELECT;
                end
            end
            PTQ_MODE_QUAD: begin
                // Both a edges, direction from the table
                event_hit  = (a_rise || a_fall) && q_en;
                event_down = quad_dir;
            end
            default: begin
                // Disabled: no counting
                event_hit = 1'b0;
            end
        endcase
    end

    // Event select filters for main and secondary counters
    function automatic logic ev_pass(input logic [1:0] sel,
                                     input logic       down);
        logic ok;
        ok = 1'b0;
        if (sel == PTQ_EV_BOTH) begin
            ok = 1'b1;
        end else if (sel == PTQ_EV_UP) begin
            ok = !down;
        end else if (sel == PTQ_EV_DOWN) begin
            ok = down;
        end
        return ok;
    endfunction

    logic main_go;   // Main counter moves this cycle
    logic sec_go;    // Secondary counter moves this cycle
    assign main_go = event_hit &&
                     ev_pass(MAIN_COUNT_EVENT_SELECT, event_down);
    assign sec_go  = event_hit &&
                     ev_pass(SECONDARY_COUNT_EVENT_SELECT,
                             event_down);

    // Wrap targets
    logic [CNT_W-1:0] half_limit;  // Midpoint reload value
    logic             main_uf;     // Underflow this cycle
    logic             main_of;     // Overflow this cycle
    assign half_limit = WRAP_LIMIT >> 1;
    assign main_uf = main_go && event_down && MAIN_COUNT_VALUE == '0;
    assign main_of = main_go && !event_down &&
                     MAIN_COUNT_VALUE == WRAP_LIMIT;

    // Main counter with wrap and midpoint reload
    logic [CNT_W-1:0] next_main;
    always_comb begin
        next_main = MAIN_COUNT_VALUE;
        if (main_uf) begin
            // Down from zero
            next_main = MIDPOINT_WRAP_ENABLE ? half_limit
                                             : WRAP_LIMIT;
        end else if (main_of) begin
            // Up past limit
            next_main = MIDPOINT_WRAP_ENABLE ? half_limit
                                             : '0;
        end else if (main_go) begin
            next_main = event_down ? MAIN_COUNT_VALUE - CNT_W'(1)
                                   : MAIN_COUNT_VALUE + CNT_W'(1);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            MAIN_COUNT_VALUE <= '0;
        end else begin
            MAIN_COUNT_VALUE <= next_main;
        end
    end

    // Secondary counter, up only, wraps past the limit
    logic sec_wrap;  // Secondary passes the limit
    assign sec_wrap = sec_go && SECONDARY_COUNT_VALUE == WRAP_LIMIT;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SECONDARY_COUNT_VALUE <= '0;
        end else if (sec_wrap) begin
            SECONDARY_COUNT_VALUE <= '0;
        end else if (sec_go) begin
            SECONDARY_COUNT_VALUE <= SECONDARY_COUNT_VALUE
                                     + CNT_W'(1);
        end
    end

    // Direction status and reversal detection in quadrature mode
    logic dir_change;  // Counted quadrature step differs from reported direction
    assign dir_change = MODE == PTQ_MODE_QUAD && event_hit &&
                        quad_dir != COUNT_SENSE_STATUS;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            COUNT_SENSE_STATUS <= 1'b0;
        end else if (MODE == PTQ_MODE_QUAD && (a_rise || a_fall)) begin
            // Invalid table entries report direction zero
            COUNT_SENSE_STATUS <= q_en ? quad_dir : 1'b0;
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            UNDERFLOW_FLAG      <= 1'b0;
            OVERFLOW_FLAG       <= 1'b0;
            REVERSAL_FLAG       <= 1'b0;
            SECONDARY_WRAP_FLAG <= 1'b0;
        end else begin
            UNDERFLOW_FLAG      <= main_uf ||
                                   (UNDERFLOW_FLAG && !FLAG_CLEAR);
            OVERFLOW_FLAG       <= main_of ||
                                   (OVERFLOW_FLAG && !FLAG_CLEAR);
            REVERSAL_FLAG       <= dir_change ||
                                   (REVERSAL_FLAG && !FLAG_CLEAR);
            SECONDARY_WRAP_FLAG <= sec_wrap ||
                                   (SECONDARY_WRAP_FLAG && !FLAG_CLEAR);
        end
    end

    // Assertions
    sequence s_at_zero_down;
        main_go && event_down && MAIN_COUNT_VALUE == '0;
    endsequence
    sequence s_at_top_up;
        main_go && !event_down && MAIN_COUNT_VALUE == WRAP_LIMIT;
    endsequence

    a_underflow_load : assert property (@(posedge CLK) disable iff (!RESET_N)
        (s_at_zero_down and !MIDPOINT_WRAP_ENABLE) |=>
        UNDERFLOW_FLAG && MAIN_COUNT_VALUE == $past(WRAP_LIMIT))
        else $error("underflow did not load limit and flag");
    a_overflow_load : assert property (@(posedge CLK) disable iff (!RESET_N)
        (s_at_top_up and !MIDPOINT_WRAP_ENABLE) |=>
        OVERFLOW_FLAG && MAIN_COUNT_VALUE == '0)
        else $error("overflow did not clear counter and flag");
    a_midpoint_wrap : assert property (@(posedge CLK) disable iff (!RESET_N)
        (main_uf || main_of) && MIDPOINT_WRAP_ENABLE |=>
        MAIN_COUNT_VALUE == ($past(WRAP_LIMIT) >> 1))
        else $error("midpoint wrap value wrong");
    a_disabled_hold : assert property (@(posedge CLK) disable iff (!RESET_N)
        MODE == PTQ_MODE_DISABLED |=> $stable(MAIN_COUNT_VALUE))
        else $error("counter moved while disabled");
    a_secondary_up : assert property (@(posedge CLK) disable iff (!RESET_N)
        sec_go && !sec_wrap |=>
        SECONDARY_COUNT_VALUE == $past(SECONDARY_COUNT_VALUE) + CNT_W'(1))
        else $error("secondary counter did not increment");
    a_secondary_wrap : assert property (@(posedge CLK) disable iff (!RESET_N)
        sec_wrap |=> SECONDARY_WRAP_FLAG && SECONDARY_COUNT_VALUE == '0)
        else $error("secondary wrap not handled");
    a_reversal_quad : assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(REVERSAL_FLAG) |-> $past(MODE) == PTQ_MODE_QUAD)
        else $error("reversal flagged outside quadrature mode");
    a_up_step : assert property (@(posedge CLK) disable iff (!RESET_N)
        main_go && !event_down && !main_of |=>
        MAIN_COUNT_VALUE == $past(MAIN_COUNT_VALUE) + CNT_W'(1))
        else $error("up count step wrong");
    a_pinclk_rise : assert property (@(posedge CLK) disable iff (!RESET_N)
        MODE == PTQ_MODE_PINCLK && event_hit |-> a_rise)
        else $error("pin clocked count without rising edge");
    a_down_step : assert property (@(posedge CLK) disable iff (!RESET_N)
        main_go && event_down && !main_uf |=>
        MAIN_COUNT_VALUE == $past(MAIN_COUNT_VALUE) - CNT_W'(1))
        else $error("down count step wrong");
    a_quad_invalid : assert property (@(posedge CLK) disable iff (!RESET_N)
        MODE == PTQ_MODE_QUAD && (a_rise || a_fall) && !q_en |=>
        !COUNT_SENSE_STATUS && $stable(MAIN_COUNT_VALUE))
        else $error("invalid quadrature step was counted");
    a_flag_clear : assert property (@(posedge CLK) disable iff (!RESET_N)
        FLAG_CLEAR && !main_of |=> !OVERFLOW_FLAG)
        else $error("overflow flag survived a clear");
    a_sense_follow : assert property (@(posedge CLK) disable iff (!RESET_N)
        MODE == PTQ_MODE_QUAD && event_hit |=>
        COUNT_SENSE_STATUS == $past(quad_dir))
        else $error("direction status does not follow counted step");
endmodule // ptq_tally

/* verification/ptq_encoder.sv */
// Far side model: pulse source and quadrature encoder on the two inputs
module ptq_encoder (
    input  wire logic clk,
    output logic      pin_a,
    output logic      pin_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both lines idle low outside frames
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // Waits n edges, then steps off the edge by the fixed skew
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Holds input a at one level for n cycles
    task automatic level(input logic v, input int n);
        pin_a = v;
        wait_cyc(n);
    endtask

    // Sets the direction line, input b
    task automatic set_b(input logic v);
        pin_b = v;
    endtask

    // One pulse on input a: hi cycles high, then lo cycles low
    task automatic pulse(input int hi, input int lo);
        level(1'b1, hi);
        level(1'b0, lo);
    endtask

    // Whole quadrature periods of 320 ns; fwd has input a leading b
    task automatic quad(input logic fwd, input int n);
        logic [7:0] seq;
        seq = fwd ? 8'hb4 : 8'h78;
        repeat (n) begin
            for (int k = 0; k < 4; k++) begin
                {pin_a, pin_b} = seq[7-2*k -: 2];
                wait_cyc(2);
            end
        end
    endtask
endmodule // ptq_encoder

/* verification/ptq_tally_bench.sv */
// Self-checking bench for the pulse and quadrature counter
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module ptq_tally_bench
    import ptq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 8;          // Narrow counters keep wraps short
    // Expected counts per select step: main by mev, secondary by sev
    localparam logic [W-1:0] EM_SEL [4] = '{8'h05, 8'h01, 8'h06, 8'h00};
    localparam logic [W-1:0] ES_SEL [4] = '{8'h00, 8'h02, 8'h01, 8'h03};
    logic          clk, reset_n;   // Main clock and reset
    logic          lfc;            // Sampling clock, 320 ns period
    logic          glitch_reject_enable, inv;      // Filter and invert controls
    logic          steer, down;    // Direction controls
    logic          mid, fclr;      // Midpoint wrap, flag clear
    ptq_mode_e     mode;           // Operating mode
    logic [1:0]    mev, sev;       // Event selects
    logic [W-1:0]  lim, em;        // Wrap limit, expected main count
    logic [W-1:0]  main_v, sec_v;  // Counter outputs
    logic          pin_a, pin_b;   // Count inputs from the model
    logic          dir_st, unf, ovf, rev, swf;  // Status and flags
    int            err_total, check_count, cyc;

    ptq_encoder p (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));
    ptq_tally #(.CNT_W(W)) DUT (
        .CLK(clk), .RESET_N(reset_n), .COUNT_INPUT_A(pin_a),
        .COUNT_INPUT_B(pin_b), .LOW_FREQ_CLOCK(lfc), .MODE(mode),
        .GLITCH_REJECT_ENABLE(glitch_reject_enable), .INPUT_INVERT(inv),
        .PIN_STEERED_DIRECTION(steer), .COUNT_DOWN_SELECT(down),
        .MIDPOINT_WRAP_ENABLE(mid), .MAIN_COUNT_EVENT_SELECT(mev),
        .SECONDARY_COUNT_EVENT_SELECT(sev), .WRAP_LIMIT(lim),
        .FLAG_CLEAR(fclr), .MAIN_COUNT_VALUE(main_v),
        .SECONDARY_COUNT_VALUE(sec_v), .COUNT_SENSE_STATUS(dir_st),
        .UNDERFLOW_FLAG(unf), .OVERFLOW_FLAG(ovf), .REVERSAL_FLAG(rev),
        .SECONDARY_WRAP_FLAG(swf));

    // Main clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Sampling clock, free running and out of phase with the main clock
    initial begin
        lfc = 1'b0;
        #7;
        forever #160 lfc = ~lfc;
    end

    // Cuts a hang short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    // Next expected main count for one counted event
    function automatic logic [W-1:0] nx(input logic [W-1:0] v,
                                        input logic dn);
        if (dn) return (v == '0) ? (mid ? lim >> 1 : lim) : v - 1'b1;
        return (v == lim) ? (mid ? lim >> 1 : '0) : v + 1'b1;
    endfunction

    // Holds reset for four cycles, then lets the design settle
    task automatic do_reset();
        reset_n = 1'b0;
        p.wait_cyc(4);
        reset_n = 1'b1;
        p.wait_cyc(2);
    endtask

    // Count pulses, then time for the last edge to land
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) p.pulse(hi, lo);
        p.wait_cyc(8);
    endtask

    // Reports the end of one test
    task automatic note(input string s);
        $display("test %s finished, mismatches %0d", s, err_total);
    endtask

    // Prints the counts and the verdict, then stops
    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main test sequence
    initial begin
        mode = PTQ_MODE_DISABLED;
        {glitch_reject_enable, inv, steer, down, mid, fclr, reset_n} = 7'h00;
        mev = PTQ_EV_BOTH;
        sev = PTQ_EV_BOTH;
        lim = 8'h05;
        em = '0;
        err_total = 0;
        check_count = 0;
        cyc = 0;
        do_reset();
        pulses(3, 4, 4);
        `CHK("main_off", 8'h00, main_v)
        note("disabled");
        // Pin clocked: every direction source, filter and invert set
        mode = PTQ_MODE_PINCLK;
        {glitch_reject_enable, inv} = 2'h3;
        do_reset();
        for (int i = 0; i < 8; i++) begin
            down = i[0];
            steer = i[1];
            p.set_b(i[2]);
            p.wait_cyc(4);
            pulses(2, 4, 4);
            repeat (2) em = nx(em, steer ? (i[2] ? down : ~down) : down);
            `CHK("main_pin", em, main_v)
        end
        `CHK("sec_both", 8'h04, sec_v)
        note("pin_clocked");
        // Midpoint and plain wraps, flag set and clear
        {mid, down, steer} = 3'h4;
        do_reset();
        pulses(8, 4, 4);
        `CHK("main_mid", 8'h04, main_v)
        `CHK("ovf_set", 1'b1, ovf)
        fclr = ~fclr;  // Clear pulse of one cycle
        p.wait_cyc(1);
        fclr = ~fclr;
        p.wait_cyc(1);
        `CHK("ovf_clr", 1'b0, ovf)
        mid = ~mid;  // Back to plain wraps
        pulses(2, 4, 4);
        `CHK("main_ovf", 8'h00, main_v)
        down = 1'b1;
        pulses(1, 4, 4);
        `CHK("main_unf", 8'h05, main_v)
        `CHK("unf_set", 1'b1, unf)
        note("wrap");
        // Event selects: main up only, secondary down only
        mev = PTQ_EV_UP;
        sev = PTQ_EV_DOWN;
        do_reset();
        pulses(3, 4, 4);
        `CHK("main_upo", 8'h00, main_v)
        `CHK("sec_dn", 8'h03, sec_v)
        down = 1'b0;
        pulses(2, 4, 4);
        `CHK("main_up", 8'h02, main_v)
        `CHK("sec_hold", 8'h03, sec_v)
        down = 1'b1;
        pulses(3, 4, 4);
        `CHK("sec_wrap", 8'h00, sec_v)
        `CHK("swf_set", 1'b1, swf)
        // Every select code: one up then two down events, limit 5 to 8
        for (int i = 0; i < 4; i++) begin
            mev = i[1:0];              // Both, up, down, none
            sev = 2'h3 - i[1:0];       // None, down, up, both
            lim = 8'h05 + 8'(i);
            do_reset();
            down = 1'b0;
            pulses(1, 4, 4);
            down = 1'b1;
            pulses(2, 4, 4);
            `CHK("main_sel", EM_SEL[i], main_v)
            `CHK("sec_sel", ES_SEL[i], sec_v)
        end
        note("events");
        // Quadrature: forward, then reverse, then inverted forward
        mev = PTQ_EV_BOTH;
        sev = PTQ_EV_NONE;
        lim = 8'h05;
        mode = PTQ_MODE_QUAD;
        {down, inv} = 2'h0;
        do_reset();
        p.quad(1'b1, 3);
        p.wait_cyc(8);
        `CHK("quad_fwd", 8'h05, main_v)
        `CHK("dir_fwd", 1'b0, dir_st)
        `CHK("rev_none", 1'b0, rev)
        p.quad(1'b0, 3);
        p.wait_cyc(8);
        `CHK("quad_bwd", 8'h00, main_v)
        `CHK("dir_bwd", 1'b1, dir_st)
        `CHK("rev_set", 1'b1, rev)
        `CHK("sec_none", 8'h00, sec_v)
        inv = 1'b1;
        do_reset();
        p.quad(1'b1, 3);
        p.wait_cyc(8);
        `CHK("quad_inv", 8'h01, main_v)
        `CHK("dir_inv", 1'b1, dir_st)
        `CHK("unf_quad", 1'b1, unf)
        note("quadrature");
        // Sampled mode with and without the glitch filter
        mode = PTQ_MODE_SAMPLED;
        {glitch_reject_enable, inv} = 2'h2;
        do_reset();
        pulses(2, 48, 48);
        `CHK("smp_glitch_reject_enable", 8'h02, main_v)
        pulses(1, 16, 48);
        `CHK("smp_glitch", 8'h02, main_v)
        glitch_reject_enable = 1'b0;
        pulses(1, 16, 48);
        `CHK("smp_raw", 8'h03, main_v)
        inv = 1'b1;
        p.level(1'b1, 8);
        do_reset();
        p.level(1'b0, 48);
        `CHK("smp_fall", 8'h01, main_v)
        p.level(1'b1, 48);
        `CHK("smp_rise", 8'h01, main_v)
        note("sampled");
        results();
    end
endmodule // ptq_tally_bench
